// >>> rtl/strap_front_map.vh
// What this block does
// - comm strap picks one of eight current limits
// - low strap half selects client mode
// - ignore bus, no acknowledge, 5.5 ms
// - first addressed read wakes from sleep
// - fully functional within 3 ms of waking
// - never hold clock low; tolerate stretching
// - start: data falls while clock high
// - first byte: 7-bit address plus direction
// - address strap gives address and enable polarity
// - address table mirrored between strap halves
// - acknowledge every received data byte
// - stop resets client, awaits new traffic
`ifndef STRAP_FRONT_MAP_VH
`define STRAP_FRONT_MAP_VH
`define CLK_PERIOD_NS 20
`define T_BLACKOUT_US 5500
`define T_WAKE_US 3000
`define BLACKOUT_CYC ((`T_BLACKOUT_US*1000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define WAKE_CYC ((`T_WAKE_US*1000)/`CLK_PERIOD_NS)
`define STRAP_FILL_CYC 19'h0_0003
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RX_DATA 8'h08
`define REG_TX_DATA 8'h0C
`define REG_HW_CURRENT_LIMIT_SETTING_MA 8'h10
`define CTRL_POWER_SWITCH_ENABLE 0
`define CTRL_SLEEP 1
`define ST_MODE 0
`define ST_HW_CURRENT_LIMIT_SETTING_LSB 1
`define ST_ADDR_LSB 4
`define ST_POL_HIGH 11
`define ST_READY 12
`define ST_ASLEEP 13
`define ST_WAKING 14
`define ST_RX_VALID 15
`define ST_LATCHED 16
`define CTRL_RST 1'h0
`define TX_RST 8'h00
`define SLEEP_RD_BYTE 8'hFF
`define CADDR_0 7'h57
`define CADDR_1 7'h56
`define CADDR_2 7'h55
`define CADDR_3 7'h54
`define CADDR_4 7'h30
`define CADDR_5 7'h31
`define CADDR_6 7'h32
`define CADDR_7 7'h33
`define HW_CURRENT_LIMIT_SETTING_0 12'h1F4
`define HW_CURRENT_LIMIT_SETTING_1 12'h384
`define HW_CURRENT_LIMIT_SETTING_2 12'h3E8
`define HW_CURRENT_LIMIT_SETTING_3 12'h4B0
`define HW_CURRENT_LIMIT_SETTING_4 12'h5DC
`define HW_CURRENT_LIMIT_SETTING_5 12'h708
`define HW_CURRENT_LIMIT_SETTING_6 12'h7D0
`define HW_CURRENT_LIMIT_SETTING_7 12'h9C4
`endif

// >>> rtl/strap_decode_smbus_client_front.v
`timescale 1ns/1ps
`include "strap_front_map.vh"
module strap_decode_smbus_client_front #(
  parameter [18:0] BLACKOUT_CYCLES = `BLACKOUT_CYC,
  parameter [18:0] WAKE_CYCLES = `WAKE_CYC
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RESET,
  // straps, level index 0 = ground .. 15 = supply
  input wire [3:0] COMM_SELECT_STRAP,
  input wire [3:0] ADDR_SELECT_STRAP,
  // serial bus
  input wire SERIAL_CLOCK_PIN,
  input wire SERIAL_DATA_IN,
  output wire SERIAL_DATA_OUT,
  output wire SERIAL_DATA_OE,
  // wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output wire [31:0] WB_DAT_O,
  output wire WB_ACK_O,
  // decoded outputs
  output wire POWER_SWITCH_ENABLE,
  output wire [2:0] HW_CURRENT_LIMIT_SETTING,
  output wire CLIENT_MODE
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_AACK = 3'h2;
  localparam [2:0] S_WR = 3'h3;
  localparam [2:0] S_WACK = 3'h4;
  localparam [2:0] S_RD = 3'h5;
  localparam [2:0] S_RACK = 3'h6;
  localparam [1:0] P_AWAKE = 2'h0;
  localparam [1:0] P_ASLEEP = 2'h1;
  localparam [1:0] P_WAKING = 2'h2;
  function [6:0] client_addr;
    input [3:0] lvl;
    reg [2:0] k;
    begin
      k = lvl[3] ? ~lvl[2:0] : lvl[2:0];
      case (k)
        3'h0: client_addr = `CADDR_0;
        3'h1: client_addr = `CADDR_1;
        3'h2: client_addr = `CADDR_2;
        3'h3: client_addr = `CADDR_3;
        3'h4: client_addr = `CADDR_4;
        3'h5: client_addr = `CADDR_5;
        3'h6: client_addr = `CADDR_6;
        default: client_addr = `CADDR_7;
      endcase
    end
  endfunction
  function [11:0] hw_current_limit_setting_ma;
    input [2:0] k;
    begin
      case (k)
        3'h0: hw_current_limit_setting_ma = `HW_CURRENT_LIMIT_SETTING_0;
        3'h1: hw_current_limit_setting_ma = `HW_CURRENT_LIMIT_SETTING_1;
        3'h2: hw_current_limit_setting_ma = `HW_CURRENT_LIMIT_SETTING_2;
        3'h3: hw_current_limit_setting_ma = `HW_CURRENT_LIMIT_SETTING_3;
        3'h4: hw_current_limit_setting_ma = `HW_CURRENT_LIMIT_SETTING_4;
        3'h5: hw_current_limit_setting_ma = `HW_CURRENT_LIMIT_SETTING_5;
        3'h6: hw_current_limit_setting_ma = `HW_CURRENT_LIMIT_SETTING_6;
        default: hw_current_limit_setting_ma = `HW_CURRENT_LIMIT_SETTING_7;
      endcase
    end
  endfunction
  // pin synchronisers; a change counts once stages 2 and 3 agree
  reg [2:0] scl_s_r;
  reg [2:0] sda_s_r;
  reg scl_f_r;
  reg sda_f_r;
  reg scl_p_r;
  reg sda_p_r;
  reg [3:0] cs1_r, cs2_r, cs3_r;
  reg [3:0] as1_r, as2_r, as3_r;

  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      cs1_r <= 4'h0;
      cs2_r <= 4'h0;
      cs3_r <= 4'h0;
      as1_r <= 4'h0;
      as2_r <= 4'h0;
      as3_r <= 4'h0;
    end else begin
      scl_s_r <= {scl_s_r[1:0], SERIAL_CLOCK_PIN};
      sda_s_r <= {sda_s_r[1:0], SERIAL_DATA_IN};
      if (scl_s_r[1] == scl_s_r[2])
        scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2])
        sda_f_r <= sda_s_r[2];
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
      cs1_r <= COMM_SELECT_STRAP;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      as1_r <= ADDR_SELECT_STRAP;
      as2_r <= as1_r;
      as3_r <= as2_r;
    end
  end
  wire scl_rise = scl_f_r & ~scl_p_r;
  wire scl_fall = ~scl_f_r & scl_p_r;
  wire start_det = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
  wire stop_det = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;

  // sync stages reset to zero, so wait until they hold the pins, then freeze
  reg [18:0] tmr_r;
  reg latched_r;
  reg smbus_mode_r;
  reg [2:0] hw_current_limit_setting_r;
  reg [6:0] addr_r;
  reg pol_high_r;

  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      latched_r <= 1'b0;
      smbus_mode_r <= 1'b0;
      hw_current_limit_setting_r <= 3'h0;
      addr_r <= 7'h00;
      pol_high_r <= 1'b0;
    end else if (!latched_r && tmr_r >= `STRAP_FILL_CYC &&
                 cs2_r == cs3_r && as2_r == as3_r) begin
      latched_r <= 1'b1;
      smbus_mode_r <= ~cs3_r[3];
      hw_current_limit_setting_r <= cs3_r[2:0];
      addr_r <= client_addr(as3_r);
      pol_high_r <= as3_r[3];
    end
  end
  // power-up blackout then sleep / wake timing share one counter
  reg ready_r;
  reg [1:0] pm_r;
  reg sleep_cmd;
  wire wake_hit;

  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      tmr_r <= 19'h0_0000;
      ready_r <= 1'b0;
      pm_r <= P_AWAKE;
    end else if (!ready_r) begin
      if (tmr_r == BLACKOUT_CYCLES - 19'h0_0001)
        ready_r <= 1'b1;
      else
        tmr_r <= tmr_r + 19'h0_0001;
    end else begin
      case (pm_r)
        P_AWAKE: begin
          if (sleep_cmd)
            pm_r <= P_ASLEEP;
        end
        P_ASLEEP: begin
          if (wake_hit) begin
            pm_r <= P_WAKING;
            tmr_r <= 19'h0_0000;
          end
        end
        P_WAKING: begin
          if (tmr_r == WAKE_CYCLES - 19'h0_0001)
            pm_r <= P_AWAKE;
          else
            tmr_r <= tmr_r + 19'h0_0001;
        end
        default: pm_r <= P_AWAKE;
      endcase
    end
  end
  wire dormant = (pm_r != P_AWAKE);
  wire client_en = ready_r & latched_r & smbus_mode_r;

  // serial client; the clock pin is input only, so it is never stretched
  reg [2:0] state_r;
  reg [3:0] cnt_r;
  reg [7:0] shin_r;
  reg [7:0] shout_r;
  reg oe_r;
  reg nack_r;
  reg [7:0] rx_data_r;
  reg [7:0] tx_data_r;

  wire addr_match = (shin_r[7:1] == addr_r);
  wire is_read = shin_r[0];
  // asleep or still waking: writes are refused, reads answer filler
  wire addr_ok = addr_match & (is_read | ~dormant);
  wire [7:0] tx_byte = dormant ? `SLEEP_RD_BYTE : tx_data_r;
  wire decide = (state_r == S_ADDR) & scl_fall & (cnt_r == 4'h8);
  assign wake_hit = decide & addr_match & is_read & (pm_r == P_ASLEEP);
  wire rx_strobe = (state_r == S_WR) & scl_fall & (cnt_r == 4'h8);

  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
      shin_r <= 8'h00;
      shout_r <= 8'h00;
      oe_r <= 1'b0;
      nack_r <= 1'b0;
      rx_data_r <= 8'h00;
    end else if (!client_en) begin
      state_r <= S_IDLE;
      oe_r <= 1'b0;
    end else if (start_det) begin
      state_r <= S_ADDR;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= S_IDLE;
      oe_r <= 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        S_ADDR, S_WR: begin
          shin_r <= {shin_r[6:0], sda_f_r};
          cnt_r <= cnt_r + 4'h1;
        end
        S_RACK: nack_r <= sda_f_r;
        default: cnt_r <= cnt_r;
      endcase
    end else if (scl_fall) begin
      // data is changed only while the clock is low
      case (state_r)
        S_ADDR: begin
          if (cnt_r == 4'h8) begin
            if (addr_ok) begin
              oe_r <= 1'b1;
              state_r <= S_AACK;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_AACK: begin
          cnt_r <= 4'h0;
          if (is_read) begin
            shout_r <= tx_byte;
            oe_r <= ~tx_byte[7];
            state_r <= S_RD;
          end else begin
            oe_r <= 1'b0;
            state_r <= S_WR;
          end
        end
        S_WR: begin
          if (cnt_r == 4'h8) begin
            rx_data_r <= shin_r;
            oe_r <= 1'b1;
            state_r <= S_WACK;
          end
        end
        S_WACK: begin
          oe_r <= 1'b0;
          cnt_r <= 4'h0;
          state_r <= S_WR;
        end
        S_RD: begin
          if (cnt_r == 4'h7) begin
            oe_r <= 1'b0;
            state_r <= S_RACK;
          end else begin
            oe_r <= ~shout_r[6];
            shout_r <= {shout_r[6:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
          end
        end
        S_RACK: begin
          cnt_r <= 4'h0;
          if (nack_r) begin
            state_r <= S_IDLE;
          end else begin
            shout_r <= tx_byte;
            oe_r <= ~tx_byte[7];
            state_r <= S_RD;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // wishbone slave, one wait state, unmapped reads give zero
  reg ack_r;
  reg [31:0] dat_r;
  reg power_switch_enable_req_r;
  reg rx_valid_r;
  reg pwr_out_r;
  wire req = WB_CYC_I & WB_STB_I & ~ack_r;
  wire wr = req & WB_WE_I;
  wire [31:0] status_w = {15'h0000, latched_r, rx_valid_r,
    pm_r == P_WAKING, pm_r == P_ASLEEP, ready_r, pol_high_r,
    addr_r, hw_current_limit_setting_r, smbus_mode_r};

  always @* begin
    sleep_cmd = wr & (WB_ADR_I == `REG_CTRL) & WB_SEL_I[0] & WB_DAT_I[`CTRL_SLEEP];
  end

  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      power_switch_enable_req_r <= `CTRL_RST;
      tx_data_r <= `TX_RST;
      rx_valid_r <= 1'b0;
      pwr_out_r <= 1'b0;
    end else begin
      ack_r <= req;
      if (req && !WB_WE_I) begin
        case (WB_ADR_I)
          `REG_CTRL: dat_r <= {31'h0000_0000, power_switch_enable_req_r};
          `REG_STATUS: dat_r <= status_w;
          `REG_RX_DATA: dat_r <= {24'h00_0000, rx_data_r};
          `REG_TX_DATA: dat_r <= {24'h00_0000, tx_data_r};
          `REG_HW_CURRENT_LIMIT_SETTING_MA: dat_r <= {20'h0_0000, hw_current_limit_setting_ma(hw_current_limit_setting_r)};
          default: dat_r <= 32'h0000_0000;
        endcase
      end
      if (wr && WB_ADR_I == `REG_CTRL && WB_SEL_I[0])
        power_switch_enable_req_r <= WB_DAT_I[`CTRL_POWER_SWITCH_ENABLE];
      if (wr && WB_ADR_I == `REG_TX_DATA && WB_SEL_I[0])
        tx_data_r <= WB_DAT_I[7:0];
      // a byte landing with the clear keeps the flag set
      if (rx_strobe)
        rx_valid_r <= 1'b1;
      else if (wr && WB_ADR_I == `REG_STATUS && WB_SEL_I[1] &&
               WB_DAT_I[`ST_RX_VALID])
        rx_valid_r <= 1'b0;
      // output held low until the strap is caught
      pwr_out_r <= latched_r & (pol_high_r ? power_switch_enable_req_r : ~power_switch_enable_req_r);
    end
  end

  reg sda_out_r;
  reg [2:0] hw_current_limit_setting_out_r;
  reg mode_out_r;
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      sda_out_r <= 1'b0;
      hw_current_limit_setting_out_r <= 3'h0;
      mode_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
      hw_current_limit_setting_out_r <= hw_current_limit_setting_r;
      mode_out_r <= smbus_mode_r & latched_r;
    end
  end

  assign SERIAL_DATA_OUT = sda_out_r;
  assign SERIAL_DATA_OE = oe_r;
  assign WB_DAT_O = dat_r;
  assign WB_ACK_O = ack_r;
  assign POWER_SWITCH_ENABLE = pwr_out_r;
  assign HW_CURRENT_LIMIT_SETTING = hw_current_limit_setting_out_r;
  assign CLIENT_MODE = mode_out_r;

endmodule

// >>> verif/strap_front_checker.sv
`timescale 1ns/1ps
module strap_front_checker #(
  parameter [18:0] BLACKOUT_CYCLES = 19'd200
) (
  input wire CORE_CLK,
  input wire RESET,
  input wire [3:0] COMM_SELECT_STRAP,
  input wire SERIAL_CLOCK_PIN,
  input wire SERIAL_DATA_OE,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_ACK_O,
  input wire POWER_SWITCH_ENABLE,
  input wire [2:0] HW_CURRENT_LIMIT_SETTING,
  input wire CLIENT_MODE
);
  reg [18:0] cnt_r;
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET)
      cnt_r <= 19'h0;
    else if (cnt_r != 19'h7_FFFF)
      cnt_r <= cnt_r + 19'h1;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ans;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  a_wb_answer: assert property (s_req |=> s_ans)
    else $error("bus request not answered by one ack");
  a_ack_caused: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_ack_held_stb: assert property (WB_ACK_O && WB_STB_I |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_mode_latch: assert property (cnt_r == 19'd19 |->
    CLIENT_MODE == !COMM_SELECT_STRAP[3] &&
    HW_CURRENT_LIMIT_SETTING == COMM_SELECT_STRAP[2:0])
    else $error("strap decode wrong");
  a_straps_held: assert property (cnt_r > 19'd19 |->
    $stable(CLIENT_MODE) && $stable(HW_CURRENT_LIMIT_SETTING))
    else $error("latched decode moved");
  a_quiet_blackout: assert property (cnt_r < BLACKOUT_CYCLES |-> !SERIAL_DATA_OE)
    else $error("data driven in blackout");
  a_quiet_alone: assert property (cnt_r > 19'd19 && !CLIENT_MODE |-> !SERIAL_DATA_OE)
    else $error("data driven in stand-alone");
  a_oe_clock_low: assert property ($changed(SERIAL_DATA_OE) |-> !SERIAL_CLOCK_PIN)
    else $error("data moved while clock high");
  a_enable_off: assert property (cnt_r < 19'd3 |-> !POWER_SWITCH_ENABLE)
    else $error("enable before latch");
endmodule

// >>> verif/smbus_host_model.sv
`timescale 1ns/1ps
module smbus_host_model (
  output logic scl,
  output logic sda_oe,
  input wire sda
);
  int lo = 3;
  initial begin
    scl = 1;
    sda_oe = 0;
  end
  // odd offset keeps the link out of phase with the core clock
  task automatic start;
    #7;
    sda_oe = 0;
    scl = 1;
    #80;
    sda_oe = 1;
    #80;
    scl = 0;
  endtask
  task automatic stop;
    sda_oe = 1;
    // full low phase: the client releases its ack some cycles after the fall
    #(80 * lo);
    scl = 1;
    #80;
    sda_oe = 0;
    #160;
  endtask
  // low phase stretched by lo, client must cope
  task automatic bitx(input logic b, output logic r);
    sda_oe = ~b;
    #(80 * lo);
    scl = 1;
    #40;
    r = sda;
    #40;
    scl = 0;
  endtask
  task automatic xfer(input [7:0] b, input logic m, output logic [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r);
      q[i] = r;
    end
    bitx(~m, r);
    ak = ~r;
  endtask
endmodule

// >>> verif/test_strap_decode_smbus_client_front.sv
`timescale 1ns/1ps
module test_strap_decode_smbus_client_front;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ak;
  logic [3:0] cs = 0, as_ = 0;
  logic [7:0] adr = 0, d;
  logic [31:0] dw = 0, q;
  wire [31:0] dr;
  wire ack, pse, cm, oe, dout, scl, hoe;
  wire [2:0] hw_current_limit_setting;
  wire sda = (oe ? dout : 1'b1) & ~hoe;
  int fails = 0, n_compared = 0;
  logic [6:0] at [8] = '{7'h57, 7'h56, 7'h55, 7'h54, 7'h30, 7'h31, 7'h32, 7'h33};
  logic [11:0] ma [8] = '{12'h1F4, 12'h384, 12'h3E8, 12'h4B0, 12'h5DC, 12'h708, 12'h7D0,
    12'h9C4};
  initial forever #10 clk = ~clk;
  strap_decode_smbus_client_front #(.BLACKOUT_CYCLES(19'd200), .WAKE_CYCLES(19'd100)) u_dut (
    .CORE_CLK(clk), .RESET(rst), .COMM_SELECT_STRAP(cs), .ADDR_SELECT_STRAP(as_),
    .SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_IN(sda), .SERIAL_DATA_OUT(dout),
    .SERIAL_DATA_OE(oe), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
    .POWER_SWITCH_ENABLE(pse), .HW_CURRENT_LIMIT_SETTING(hw_current_limit_setting), .CLIENT_MODE(cm));
  smbus_host_model u_host (.scl(scl), .sda_oe(hoe), .sda(sda));
  task automatic chk(input [31:0] g, input [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input [7:0] a, input [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dw <= v;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dr;
    if (n >= 40) chk(ack, 1);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic hb(input [7:0] b, input logic m);
    u_host.xfer(b, m, d, ak);
  endtask
  task automatic rst_to(input [3:0] c, input [3:0] a);
    rst <= 1;
    cs <= c;
    as_ <= a;
    repeat (5) @(posedge clk);
    rst <= 0;
    repeat (20) @(posedge clk);
  endtask
  task automatic t_straps;
    for (int k = 0; k < 16; k++) begin
      rst_to(k, k);
      chk(hw_current_limit_setting, k[2:0]);
      chk(cm, !k[3]);
      wb(0, 8'h04, 0);
      chk(q[11:4], {k[3], at[k[3] ? 15 - k : k]});
      wb(0, 8'h10, 0);
      chk(q, {20'h0_0000, ma[k[2:0]]});
      wb(1, 8'h00, 1);
      cs <= ~cs;
      repeat (8) @(posedge clk);
      chk(pse, k[3]);
      chk({cm, hw_current_limit_setting}, {~k[3], k[2:0]});
    end
    $display("straps done");
  endtask
  task automatic t_link;
    rst_to(4'h0, 4'h0);
    u_host.lo = 1;
    u_host.start;
    hb(8'hAE, 0);
    chk(ak, 0);
    u_host.stop;
    repeat (200) @(posedge clk);
    u_host.lo = 6;
    u_host.start;
    hb(8'hAE, 0);
    chk(ak, 1);
    hb(8'hA5, 0);
    chk(ak, 1);
    u_host.stop;
    u_host.lo = 3;
    wb(0, 8'h08, 0);
    chk(q[7:0], 8'hA5);
    wb(0, 8'h04, 0);
    chk(q[15], 1);
    wb(1, 8'h04, 32'h0000_8000);
    wb(0, 8'h04, 0);
    chk(q[15], 0);
    wb(1, 8'h0C, 8'h3C);
    u_host.start;
    hb(8'hAF, 0);
    chk(ak, 1);
    hb(8'hFF, 1);
    chk(d, 8'h3C);
    hb(8'hFF, 0);
    chk(d, 8'h3C);
    u_host.stop;
    u_host.start;
    hb(8'hAC, 0);
    chk(ak, 0);
    u_host.stop;
    wb(0, 8'h40, 0);
    chk(q, 0);
    $display("link done");
  endtask
  task automatic t_sleep;
    wb(1, 8'h00, 2);
    wb(0, 8'h04, 0);
    chk(q[13], 1);
    u_host.start;
    hb(8'hAE, 0);
    chk(ak, 0);
    u_host.stop;
    u_host.start;
    hb(8'hAF, 0);
    chk(ak, 1);
    wb(0, 8'h04, 0);
    chk(q[14], 1);
    hb(8'hFF, 0);
    chk(d, 8'hFF);
    u_host.stop;
    repeat (110) @(posedge clk);
    u_host.start;
    hb(8'hAE, 0);
    chk(ak, 1);
    hb(8'h5A, 0);
    u_host.stop;
    wb(0, 8'h08, 0);
    chk(q[7:0], 8'h5A);
    $display("sleep done");
  endtask
  task automatic t_alone;
    rst_to(4'h8, 4'h0);
    repeat (200) @(posedge clk);
    u_host.start;
    hb(8'hAE, 0);
    chk(ak, 0);
    u_host.stop;
    $display("stand-alone done");
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    t_straps;
    t_link;
    t_sleep;
    t_alone;
    end_of_test;
  end
  initial begin
    #1000000;
    fails++;
    end_of_test;
  end
endmodule
bind strap_decode_smbus_client_front strap_front_checker #(
  .BLACKOUT_CYCLES(BLACKOUT_CYCLES)) u_chk (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .COMM_SELECT_STRAP(COMM_SELECT_STRAP),
  .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SERIAL_DATA_OE(SERIAL_DATA_OE),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .POWER_SWITCH_ENABLE(POWER_SWITCH_ENABLE),
  .HW_CURRENT_LIMIT_SETTING(HW_CURRENT_LIMIT_SETTING), .CLIENT_MODE(CLIENT_MODE));
